// >>> hw/swdbg_ctrl.sv
// swdbg_ctrl: single-wire debug controller, mode select, serial engine, command decode
// assumes the core answers access requests through the two-entry buffer; pin via in/out/oe
`timescale 1ns/1ps
`default_nettype none
module swdbg_ctrl
    import swdbg_pkg::*;
#(
    parameter int unsigned DATA_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire swdbg_rst_cause_t rst_cause,
    input  wire logic             debug_pin_in,
    output logic                  debug_pin_out,
    output logic                  debug_pin_oe_n,
    output logic                  debug_pin_pullup_en,
    output logic                  req_valid,
    input  wire logic             req_ready,
    output swdbg_req_t            req,
    input  wire logic             rsp_valid,
    output logic                  rsp_ready,
    input  wire logic [15:0]      rsp_data,
    input  wire logic             cpu_addr_valid,
    input  wire logic [15:0]      cpu_addr,
    input  wire logic             cpu_in_stop_wait,
    output logic                  background_mode,
    output logic                  go_pulse,
    output logic                  trace_pulse,
    output logic                  wake_pulse,
    output logic                  bkpt_hit,
    output logic                  osc_keep_run,
    output logic                  watchdog_disable
);
    initial begin
        if (DATA_W != 16) $error("swdbg_ctrl: DATA_W must be 16");
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_EXEC, ST_WAIT, ST_DELAY, ST_RDATA
    } swdbg_state_t;

    typedef enum logic [1:0] {BIT_IDLE, BIT_ACTIVE} swdbg_bit_t;

    localparam logic [CNT_W-1:0] C_SAMPLE  = CNT_W'(SAMPLE_CYCLES);
    localparam logic [CNT_W-1:0] C_ZERO    = CNT_W'(ZERO_LOW_CYCLES);
    localparam logic [CNT_W-1:0] C_SPEED   = CNT_W'(SPEEDUP_CYCLES);
    localparam logic [CNT_W-1:0] C_BIT     = CNT_W'(BIT_CYCLES);
    localparam logic [CNT_W-1:0] C_TMO     = CNT_W'(TIMEOUT_CYCLES - 1);
    localparam logic [CNT_W-1:0] C_SYNCMIN = CNT_W'(SYNC_MIN_LOW);
    localparam logic [CNT_W-1:0] C_SYNCP   = CNT_W'(SYNC_PULSE_CYCLES);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg  <= 1'b1;
        end else begin
            sync1_reg <= debug_pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    // bit start on host falling edge
    logic fall;
    assign fall = prev_reg && !sync2_reg;

    // mode selection at reset release
    logic strap_done_reg;
    logic bkg_reg;
    logic force_flag_reg;
    logic force_win_reg;
    logic [7:0] ctrl_reg;
    logic [15:0] bkpt_reg;

    // bit engine
    swdbg_bit_t   bit_state_reg;
    logic [CNT_W-1:0] bcnt_reg;
    logic [CNT_W-1:0] gap_reg;
    logic         tx_mode_reg;
    logic         tx_bit_reg;
    logic         bit_done;
    logic         rx_bit;
    logic         timeout;
    logic         low_run_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic         sync_req;
    logic [CNT_W-1:0] sync_cnt_reg;
    logic         sync_wait_reg;

    swdbg_state_t st_reg;
    logic [7:0]   cmd_reg;
    logic [15:0]  shreg_reg;
    logic [4:0]   nbits_reg;
    logic [15:0]  addr_reg;
    logic [15:0]  rdata_reg;
    logic [4:0]   dly_reg;
    logic         go_cmd;
    logic         restricted;
    logic         cmd_writes;
    logic         cmd_reads;

    // sample at ten cycles, bit lasts sixteen
    assign rx_bit   = (bit_state_reg == BIT_ACTIVE) && (bcnt_reg == C_SAMPLE) && !tx_mode_reg;
    assign bit_done = (bit_state_reg == BIT_ACTIVE) && (bcnt_reg == C_BIT);
    assign timeout  = (gap_reg == C_TMO) && (st_reg != ST_IDLE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_state_reg <= BIT_IDLE;
            bcnt_reg      <= '0;
            gap_reg       <= '0;
        end else begin
            if (fall || st_reg == ST_IDLE) gap_reg <= '0;
            else if (gap_reg != C_TMO) gap_reg <= gap_reg + 1'b1;
            if (fall && !sync_wait_reg) begin
                bit_state_reg <= BIT_ACTIVE;
                bcnt_reg      <= '0;
            end else if (bit_state_reg == BIT_ACTIVE) begin
                if (bit_done) bit_state_reg <= BIT_IDLE;
                else bcnt_reg <= bcnt_reg + 1'b1;
            end
        end
    end

    // sync request: host holds pin low far longer than one bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= '0;
            low_run_reg <= 1'b0;
        end else if (!sync2_reg && !sync_wait_reg) begin
            // own sync reply must not look like a new request
            if (low_cnt_reg != C_SYNCMIN) low_cnt_reg <= low_cnt_reg + 1'b1;
            low_run_reg <= (low_cnt_reg == C_SYNCMIN);
        end else begin
            low_cnt_reg <= '0;
            low_run_reg <= 1'b0;
        end
    end
    assign sync_req = low_run_reg && sync2_reg;

    // timed sync response pulse after host releases
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_wait_reg <= 1'b0;
            sync_cnt_reg  <= '0;
        end else if (low_cnt_reg == C_SYNCMIN && sync2_reg && !sync_wait_reg) begin
            sync_wait_reg <= 1'b1;
            sync_cnt_reg  <= '0;
        end else if (sync_wait_reg) begin
            sync_cnt_reg <= sync_cnt_reg + 1'b1;
            if (sync_cnt_reg == C_SYNCP + C_BIT) sync_wait_reg <= 1'b0;
        end
    end

    // pin drive: low for a zero, speedup high pulses
    always_comb begin
        debug_pin_oe_n = 1'b1;
        debug_pin_out  = 1'b1;
        if (sync_wait_reg && sync_cnt_reg >= C_BIT) begin
            debug_pin_oe_n = 1'b0;
            debug_pin_out  = (sync_cnt_reg == C_SYNCP + C_BIT);
        end else if (bit_state_reg == BIT_ACTIVE && tx_mode_reg) begin
            if (!tx_bit_reg && bcnt_reg < C_ZERO) begin
                debug_pin_oe_n = 1'b0;
                debug_pin_out  = 1'b0;
            end else if (!tx_bit_reg && bcnt_reg == C_ZERO) begin
                debug_pin_oe_n = 1'b0;
            end else if (tx_bit_reg && bcnt_reg == C_SPEED) begin
                debug_pin_oe_n = 1'b0;
            end
        end
    end
    assign debug_pin_pullup_en = 1'b1;

    assign restricted = (cmd_reg == CMD_GO) || (cmd_reg == CMD_TRACE) ||
                        (cmd_reg[7:5] == 3'b011) || (cmd_reg[7:5] == 3'b010);
    assign cmd_writes = (cmd_reg[7:1] == CMD_WRITE_BYTE[7:1]) || (cmd_reg[7:5] == 3'b010);
    assign cmd_reads  = (cmd_reg[7:1] == CMD_READ_BYTE[7:1]) || (cmd_reg[7:5] == 3'b011);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= ST_IDLE;
            cmd_reg     <= '0;
            shreg_reg   <= '0;
            nbits_reg   <= '0;
            addr_reg    <= '0;
            rdata_reg   <= '0;
            dly_reg     <= '0;
            tx_mode_reg <= 1'b0;
            tx_bit_reg  <= 1'b1;
        end else if (timeout || sync_req) begin
            st_reg      <= ST_IDLE;
            tx_mode_reg <= 1'b0;
        end else begin
            if (rx_bit) shreg_reg <= {shreg_reg[14:0], sync2_reg};
            case (st_reg)
            ST_IDLE: begin
                if (fall) begin
                    st_reg    <= ST_CMD;
                    nbits_reg <= 5'd8;
                end
            end
            ST_CMD, ST_ADDR, ST_WDATA: begin
                if (rx_bit && nbits_reg == 5'd1) begin
                    if (st_reg == ST_CMD) begin
                        cmd_reg <= {shreg_reg[6:0], sync2_reg};
                        st_reg  <= ST_EXEC;
                    end else if (st_reg == ST_ADDR) begin
                        addr_reg  <= {shreg_reg[14:0], sync2_reg};
                        st_reg    <= cmd_writes ? ST_WDATA : ST_EXEC;
                        nbits_reg <= (cmd_reg[7:5] == 3'b010) ? 5'd16 : 5'd8;
                    end else begin
                        rdata_reg <= {shreg_reg[14:0], sync2_reg};
                        st_reg    <= ST_WAIT;
                    end
                end else if (rx_bit) begin
                    nbits_reg <= nbits_reg - 1'b1;
                end
            end
            ST_EXEC: begin
                // a reply must not start inside the command's own last bit
                if (bit_state_reg == BIT_ACTIVE) st_reg <= ST_EXEC;
                else if (restricted && !bkg_reg) st_reg <= ST_IDLE;
                else if (cmd_reg == CMD_READ_BYTE || cmd_reg == CMD_WRITE_BYTE) begin
                    st_reg    <= ST_ADDR;
                    nbits_reg <= 5'd16;
                    cmd_reg[0] <= 1'b1;
                end else if (cmd_reg == {CMD_READ_BYTE[7:1], 1'b1}) begin
                    st_reg <= ST_WAIT;
                end else if (cmd_reg[7:5] == 3'b010 || cmd_reg[7:5] == 3'b011) begin
                    addr_reg  <= {11'h000, cmd_reg[4:0]};
                    st_reg    <= cmd_writes ? ST_WDATA : ST_WAIT;
                    nbits_reg <= 5'd16;
                end else if (cmd_reg == CMD_WRITE_CONTROL || cmd_reg == CMD_FORCE_BKG) begin
                    st_reg    <= ST_WDATA;
                    nbits_reg <= 5'd8;
                end else if (cmd_reg == CMD_WRITE_BKPT) begin
                    st_reg    <= ST_WDATA;
                    nbits_reg <= 5'd16;
                end else if (cmd_reg == CMD_READ_STATUS || cmd_reg == CMD_READ_BKPT) begin
                    rdata_reg   <= (cmd_reg == CMD_READ_BKPT) ? bkpt_reg
                                 : {ctrl_reg, bkg_reg, 7'h00};
                    nbits_reg   <= (cmd_reg == CMD_READ_BKPT) ? 5'd16 : 5'd8;
                    st_reg      <= ST_RDATA;
                    tx_mode_reg <= 1'b1;
                    tx_bit_reg  <= (cmd_reg == CMD_READ_BKPT) ? bkpt_reg[15] : ctrl_reg[7];
                end else begin
                    st_reg  <= ST_DELAY;
                    dly_reg <= 5'(DELAY_CYCLES);
                end
            end
            ST_WAIT: begin
                if (rb_valid && cmd_reads) begin
                    rdata_reg   <= (cmd_reg[7:5] == 3'b011) ? rb_data : {rb_data[7:0], 8'h00};
                    nbits_reg   <= (cmd_reg[7:5] == 3'b011) ? 5'd16 : 5'd8;
                    tx_bit_reg  <= (cmd_reg[7:5] == 3'b011) ? rb_data[15] : rb_data[7];
                    tx_mode_reg <= 1'b1;
                    st_reg      <= ST_RDATA;
                end else if (!cmd_reads) begin
                    st_reg  <= ST_DELAY;
                    dly_reg <= 5'(DELAY_CYCLES);
                end
            end
            ST_DELAY: begin
                if (dly_reg != 5'd0) dly_reg <= dly_reg - 1'b1;
                else st_reg <= ST_IDLE;
            end
            ST_RDATA: begin
                if (bit_done) begin
                    if (nbits_reg == 5'd1) begin
                        st_reg      <= ST_IDLE;
                        tx_mode_reg <= 1'b0;
                    end else begin
                        nbits_reg  <= nbits_reg - 1'b1;
                        rdata_reg  <= {rdata_reg[14:0], 1'b0};
                        tx_bit_reg <= rdata_reg[14];
                    end
                end
            end
            default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // access request: memory data arrives in low byte, words for cpu registers
    logic req_fire_reg;
    logic exec_go;
    assign exec_go = (st_reg == ST_EXEC) && (bit_state_reg != BIT_ACTIVE);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) req_fire_reg <= 1'b0;
        else req_fire_reg <= (exec_go && cmd_reg == {CMD_READ_BYTE[7:1], 1'b1})
                             || (st_reg == ST_WDATA && rx_bit && nbits_reg == 5'd1 && cmd_writes)
                             || (exec_go && cmd_reg[7:5] == 3'b011 && bkg_reg);
    end
    assign req_valid     = req_fire_reg;
    assign req.write     = cmd_reg[6] == 1'b0 || cmd_reg[7:1] == CMD_WRITE_BYTE[7:1];
    assign req.cpu_reg   = cmd_reg[7:6] == 2'b01;
    assign req.addr      = addr_reg;
    assign req.wdata     = rdata_reg;

    // buffered response path: a stalled engine loses no word
    logic        rb_valid;
    logic [15:0] rb_data;
    swdbg_buf2 #(.WIDTH(16)) u_rsp_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (rsp_valid),
        .in_ready  (rsp_ready),
        .in_data   (rsp_data),
        .out_valid (rb_valid),
        .out_ready (st_reg == ST_WAIT),
        .out_data  (rb_data)
    );

    // control, breakpoint and background mode state
    assign go_cmd = (st_reg == ST_DELAY) && (dly_reg == 5'd0) && bkg_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg       <= CTRL_RESET;
            bkpt_reg       <= BKPT_RESET;
            force_flag_reg <= 1'b0;
        end else if (st_reg == ST_WDATA && rx_bit && nbits_reg == 5'd1) begin
            if (cmd_reg == CMD_WRITE_CONTROL) ctrl_reg <= {shreg_reg[6:0], sync2_reg};
            if (cmd_reg == CMD_WRITE_BKPT) bkpt_reg <= {shreg_reg[14:0], sync2_reg};
            // force flag written by serial command
            if (cmd_reg == CMD_FORCE_BKG) force_flag_reg <= sync2_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            bkg_reg        <= 1'b0;
            force_win_reg  <= 1'b0;
            go_pulse       <= 1'b0;
            trace_pulse    <= 1'b0;
            wake_pulse     <= 1'b0;
        end else begin
            go_pulse    <= 1'b0;
            trace_pulse <= 1'b0;
            wake_pulse  <= 1'b0;
            force_win_reg <= force_flag_reg && st_reg == ST_IDLE;
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                // strap only on power-on, pulled-up pin means user
                bkg_reg <= (rst_cause == SWDBG_RST_POR) && !debug_pin_in;
            end else if (force_win_reg && !sync2_reg && !bkg_reg) begin
                // pin low right after force flag
                bkg_reg <= 1'b1;
            end else if (st_reg == ST_DELAY && dly_reg == 5'd0) begin
                if (cmd_reg == CMD_BACKGROUND && ctrl_reg[CTRL_ENABLE_BIT]) begin
                    bkg_reg <= 1'b1;
                    wake_pulse <= cpu_in_stop_wait;
                end else if (go_cmd && cmd_reg == CMD_GO) begin
                    bkg_reg  <= 1'b0;
                    go_pulse <= 1'b1;
                end else if (go_cmd && cmd_reg == CMD_TRACE) begin
                    trace_pulse <= 1'b1;
                end
            end else if (bkpt_hit) begin
                bkg_reg <= 1'b1;
            end
        end
    end

    assign bkpt_hit = ctrl_reg[CTRL_BKPT_EN_BIT] && cpu_addr_valid && (cpu_addr == bkpt_reg)
                      && !bkg_reg;
    assign background_mode  = bkg_reg;
    assign osc_keep_run     = ctrl_reg[CTRL_ENABLE_BIT];
    assign watchdog_disable = bkg_reg;
    logic unused_ok;
    assign unused_ok = req_ready;
endmodule : swdbg_ctrl
`default_nettype wire

// >>> hw/swdbg_pkg.sv
// swdbg_pkg: constants, types and command codes for the single-wire debug controller
// assumes one 40 MHz debug clock; the serial host is asynchronous to it
package swdbg_pkg;
    localparam int unsigned CLK_MHZ          = 40;
    localparam int unsigned BIT_CYCLES       = 16;
    localparam int unsigned TIMEOUT_CYCLES   = 512;
    localparam int unsigned SAMPLE_CYCLES    = 10;
    localparam int unsigned ZERO_LOW_CYCLES  = 13;
    localparam int unsigned SPEEDUP_CYCLES   = 7;
    localparam int unsigned SPEEDUP_LEN      = 1;
    localparam int unsigned SYNC_LOW_CYCLES  = 128;
    localparam int unsigned SYNC_MIN_LOW     = 64;
    localparam int unsigned SYNC_PULSE_CYCLES = 128;
    localparam int unsigned DELAY_CYCLES     = 16;
    localparam int unsigned CNT_W            = 10;

    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
    localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
    localparam logic [7:0] CMD_READ_BYTE  = 8'hE0;
    localparam logic [7:0] CMD_WRITE_BYTE = 8'hC0;
    localparam logic [7:0] CMD_READ_BKPT  = 8'hE2;
    localparam logic [7:0] CMD_WRITE_BKPT = 8'hC2;
    localparam logic [7:0] CMD_GO         = 8'h08;
    localparam logic [7:0] CMD_TRACE      = 8'h10;
    localparam logic [7:0] CMD_READ_REG   = 8'h60;
    localparam logic [7:0] CMD_WRITE_REG  = 8'h40;
    localparam logic [7:0] CMD_FORCE_BKG  = 8'hC8;

    localparam int unsigned CTRL_ENABLE_BIT = 7;
    localparam int unsigned CTRL_BKPT_EN_BIT = 6;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [15:0] BKPT_RESET     = 16'h0000;

    typedef enum logic [1:0] {
        SWDBG_RST_POR,
        SWDBG_RST_PIN,
        SWDBG_RST_ERR
    } swdbg_rst_cause_t;

    // memory / cpu register access request towards the core
    typedef struct packed {
        logic        write;
        logic        cpu_reg;
        logic [15:0] addr;
        logic [15:0] wdata;
    } swdbg_req_t;
endpackage : swdbg_pkg

// >>> hw/swdbg_buf2.sv
// swdbg_buf2: two-entry valid/ready buffer
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module swdbg_buf2 #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    initial begin
        if (WIDTH < 1) $error("swdbg_buf2: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] mem_reg [2];
    logic             wp_reg;
    logic             rp_reg;
    logic [1:0]       cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != 2'd2);
    assign out_valid = (cnt_reg != 2'd0);
    assign out_data  = mem_reg[rp_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'd0;
        end else begin
            if (push) wp_reg <= ~wp_reg;
            if (pop) rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : swdbg_buf2
`default_nettype wire

// >>> tb/swdbg_ctrl_sva.sv
// swdbg_ctrl_sva: pin timing and mode checks for the debug controller
// assumes a bind to swdbg_ctrl; debug_pin_in is the resolved pin level
`timescale 1ns/1ps
`default_nettype none
module swdbg_ctrl_sva
    import swdbg_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             rst_n,
    input wire swdbg_rst_cause_t rst_cause,
    input wire logic             debug_pin_in,
    input wire logic             debug_pin_out,
    input wire logic             debug_pin_oe_n,
    input wire logic             background_mode,
    input wire logic             go_pulse,
    input wire logic             trace_pulse,
    input wire logic             watchdog_disable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_reg;
    wire        drv_low = !debug_pin_oe_n && !debug_pin_out;
    // length of the current low drive, read when it ends
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) low_reg <= 8'h00;
        else low_reg <= drv_low ? low_reg + 8'h01 : 8'h00;
    end
    wd_mode_a: assert property (watchdog_disable == background_mode)
        else $error("watchdog disable differs from mode");
    user_reset_a: assert property ($rose(rst_n) && (rst_cause != SWDBG_RST_POR || debug_pin_in)
        |=> !background_mode) else $error("background entered on user reset");
    bkg_reset_a: assert property ($rose(rst_n) && rst_cause == SWDBG_RST_POR && !debug_pin_in
        |-> ##[1:4] background_mode) else $error("por with low pin stayed in user mode");
    quiet_reset_a: assert property ($rose(rst_n) |-> debug_pin_oe_n [*3])
        else $error("pin driven without host edge");
    low_len_a: assert property (low_reg != 8'h00 && !drv_low |-> !debug_pin_oe_n && debug_pin_out
        && (low_reg == 8'(ZERO_LOW_CYCLES) || low_reg == 8'(SYNC_LOW_CYCLES)))
        else $error("low drive of wrong length or no speedup");
    brief_high_a: assert property (!debug_pin_oe_n && debug_pin_out |=> debug_pin_oe_n)
        else $error("speedup pulse too long");
    host_edge_a: assert property ($fell(debug_pin_in) && debug_pin_oe_n |-> debug_pin_oe_n [*2])
        else $error("device drove against host edge");
    run_halted_a: assert property (go_pulse || trace_pulse |-> $past(background_mode))
        else $error("run command outside background");
    cover property (drv_low ##1 low_reg == 8'(SYNC_LOW_CYCLES));
    cover property (go_pulse);
    cover property ($rose(background_mode));
endmodule : swdbg_ctrl_sva
`default_nettype wire

// >>> tb/swdbg_pod.sv
// swdbg_pod: debug pod model, the serial host clocking every bit
// assumes an open-drain pin: it only pulls low, the pullup gives high
`timescale 1ns/1ps
`default_nettype none
module swdbg_pod (
    input  wire logic sys_clk,
    input  wire logic pin,
    output logic      pod_low
);
    initial pod_low = 1'b0;
    task automatic hold(input logic v);
        pod_low = v;
    endtask : hold
    // falling edge opens each 20-cycle bit; a one releases early
    task automatic bit_io(input logic b, output logic r);
        @(posedge sys_clk);
        #2;
        pod_low = 1'b1;
        for (int i = 0; i < 19; i++) begin
            @(posedge sys_clk);
            #2;
            if (i == 10) r = pin;
            if (i == (b ? 2 : 15)) pod_low = 1'b0;
        end
    endtask : bit_io
    // msb first both ways; reading sends ones
    task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
        logic r;
        q = 16'h0000;
        for (int k = n - 1; k >= 0; k--) begin
            bit_io(d[k], r);
            q[k] = r;
        end
    endtask : xfer
    // long low, then count the reply's low cycles
    task automatic sync(output int lo);
        @(posedge sys_clk);
        #2;
        pod_low = 1'b1;
        repeat (70) @(posedge sys_clk);
        #2;
        pod_low = 1'b0;
        lo = 0;
        repeat (300) begin
            @(posedge sys_clk);
            #2;
            lo += int'(pin === 1'b0);
        end
    endtask : sync
endmodule : swdbg_pod
`default_nettype wire

// >>> tb/swdbg_ctrl_tb_top.sv
// swdbg_ctrl_tb_top: self-checking bench for the debug controller
// assumes swdbg_pod as host and a core that answers one cycle after a request
`timescale 1ns/1ps
`default_nettype none
module swdbg_ctrl_tb_top;
    import swdbg_pkg::*;
    logic             sys_clk = 1'b0, rst_n = 1'b0, req_ready = 1'b0, rsp_valid = 1'b0;
    logic             cpu_addr_valid = 1'b0, cpu_in_stop_wait = 1'b0, hv;
    logic             pod_low, dout, oe_n, pu, req_valid, rsp_ready, bkg, go_p, tr_p, wk_p;
    logic             hit, osc, wd;
    logic [15:0]      rsp_data = 16'h0000, cpu_addr = 16'h0000, last_addr, q, a;
    logic [7:0]       cb;
    swdbg_rst_cause_t rst_cause = SWDBG_RST_POR;
    swdbg_req_t       req;
    int               fails = 0, n_compared = 0, seed = 32'h1bf8;
    int               n_go = 0, n_tr = 0, n_wk = 0, lo, g, w;
    wire              pin = !oe_n ? dout : (pod_low ? 1'b0 : pu);
    always #12.5 sys_clk = ~sys_clk;
    swdbg_ctrl i_dut (.sys_clk, .rst_n, .rst_cause, .debug_pin_in(pin), .debug_pin_out(dout),
        .debug_pin_oe_n(oe_n), .debug_pin_pullup_en(pu), .req_valid, .req_ready, .req,
        .rsp_valid, .rsp_ready, .rsp_data, .cpu_addr_valid, .cpu_addr, .cpu_in_stop_wait,
        .background_mode(bkg), .go_pulse(go_p), .trace_pulse(tr_p), .wake_pulse(wk_p),
        .bkpt_hit(hit), .osc_keep_run(osc), .watchdog_disable(wd));
    swdbg_pod i_pod (.sys_clk, .pin, .pod_low);
    function automatic logic [15:0] exp_rd(logic [15:0] ad);
        return {ad[7:0], ad[15:8] ^ 8'h3c};
    endfunction : exp_rd
    // core stand-in: answers a request one cycle later, random side inputs
    always @(posedge sys_clk) begin
        #2;
        n_go += go_p;
        n_tr += tr_p;
        n_wk += wk_p;
        hv = req_valid === 1'b1;
        if (hv) last_addr = req.addr;
        rsp_valid = hv;
        rsp_data = exp_rd(last_addr);
        req_ready = 1'($random(seed));
        cpu_addr_valid = 1'($random(seed));
        cpu_addr = 16'($random(seed));
    end
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cmd(logic [7:0] c, logic [15:0] d, int n);
        i_pod.xfer({8'h00, c}, 8, q);
        repeat (20) @(posedge sys_clk);
        if (n > 0) i_pod.xfer(d, n, q);
        repeat (20) @(posedge sys_clk);
    endtask : cmd
    task automatic do_reset(swdbg_rst_cause_t c, logic low);
        @(posedge sys_clk);
        #2;
        rst_n = 1'b0;
        rst_cause = c;
        i_pod.hold(low);
        repeat (20) @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        i_pod.hold(1'b0);
        repeat (4) @(posedge sys_clk);
    endtask : do_reset
    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset(swdbg_rst_cause_t'(i % 3), i != 3);
            chk("background_mode", {15'h0000, i == 0}, {15'h0000, bkg});
            chk("watchdog_disable", {15'h0000, i == 0}, {15'h0000, wd});
        end
        g = n_go + n_tr;
        cmd(CMD_GO, 16'h0000, 0);
        cmd(CMD_TRACE, 16'h0000, 0);
        chk("refused_runs", 16'(g), 16'(n_go + n_tr));
        cb = 8'($random(seed)) & 8'hbf | 8'h80;
        cmd(CMD_WRITE_CONTROL, {8'h00, cb}, 8);
        chk("osc_keep_run", {15'h0000, cb[7]}, {15'h0000, osc});
        i_pod.xfer({8'h00, CMD_WRITE_CONTROL}, 8, q);
        i_pod.xfer(16'h000a, 4, q);
        repeat (600) @(posedge sys_clk);
        cmd(CMD_READ_STATUS, 16'hffff, 8);
        chk("status", {8'h00, cb}, q);
        for (int i = 0; i < 3; i++) begin
            a = 16'($random(seed));
            i_pod.xfer({8'h00, CMD_READ_BYTE}, 8, q);
            cmd(a[15:8], {8'hff, a[7:0]}, 8);
            i_pod.xfer(16'hffff, 8, q);
            chk("read_byte", exp_rd(a) & 16'h00ff, q);
            chk("req_addr", a, last_addr);
        end
        #2 cpu_in_stop_wait = 1'b1;
        for (int i = 0; i < 2; i++) begin
            w = n_wk;
            g = n_go + n_tr;
            cmd(CMD_BACKGROUND, 16'h0000, 0);
            chk("wake", 16'(w + 1), 16'(n_wk));
            chk("background_mode", 16'h0001, {15'h0000, bkg});
            cmd(i == 1 ? CMD_TRACE : CMD_GO, 16'h0000, 0);
            chk("run_pulse", 16'(g + 1), 16'(n_go + n_tr));
        end
        i_pod.sync(lo);
        chk("sync_low", 16'(SYNC_LOW_CYCLES), 16'(lo));
        print_verdict();
    end
endmodule : swdbg_ctrl_tb_top
bind swdbg_ctrl swdbg_ctrl_sva i_sva (.sys_clk, .rst_n, .rst_cause, .debug_pin_in,
    .debug_pin_out, .debug_pin_oe_n, .background_mode, .go_pulse, .trace_pulse,
    .watchdog_disable);
`default_nettype wire
